// File: verilog/stpls_top.sv
// Behaviour
// - mode 15: 9-bit samples plus 000 pad; lane k carries k and k+4
// - sync header error check is CRC-12 only; no 3-bit CRC option
// - sync header may instead carry forward error correction
// - redundant lanes allowed only when link mode uses four lanes or fewer
// - alternate select clear routes to D3-D0, set routes to D7-D4
// - only one lane group driven at a time, other group idle, except in eight-lane mode 15 where both groups drive
// - power-down pin high disables every serial output driver
// - power-down keeps all register settings
// - powered lanes follow link mode whatever test pattern runs
// - prbs modes bypass transport and link layers
// - each lane starts its prbs from its own phase
// - prbs7/9/15 use taps 6^7, 5^9, 14^15
// - prbs23 uses taps 18^23, prbs31 uses 28^31
// - clock pattern: eight ones then eight zeros, link layers bypassed
// - ramp: link layer normal, transport off, formatter ignored
// - ramp starts after ila (8b/10b) or serializer init (64b/66b)
// - ramp: every lane same octet stream 00..ff wrapping
// - short transport pattern repeats identically every frame
// - no long transport test mode
// - mode 0 short pattern: five words per lane plus tail nibble
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stpls_params.svh"

module stpls_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        power_down_pin,
  input  wire logic        serdes_init_done,
  input  wire logic        ila_done,
  input  wire logic [71:0] sample_a,
  input  wire logic [71:0] sample_b,
  output logic             sample_take,
  output logic [31:0]      lane_nibble,
  output logic [7:0]       lane_drv_en,
  output logic             link_bypass,
  output logic             transport_active,
  output logic             link_enc_8b10b,
  output logic             sh_use_crc12,
  output logic             sh_use_fec
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic arst_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      arst_n   <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      arst_n   <= rst_meta;
    end
  end

  // ==========================================================
  // axi4-lite slave
  logic [31:0] ctrl;
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        ramp_run;

  wire        do_write = clk_en && aw_full && w_full && !s_axi_bvalid;
  wire        wr_ctrl  = aw_addr == `STP_CTRL_ADDR;
  wire        link_en  = ctrl[`STP_LINK_EN_BIT];
  wire [31:0] byte_msk = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  // a running link keeps its pattern select; the write lands on the other fields
  wire [31:0] wr_msk   = byte_msk & `STP_CTRL_WMASK & (link_en ? ~`STP_TP_MASK : 32'hffff_ffff);
  wire [31:0] next_ctrl = (ctrl & ~wr_msk) | (w_data & wr_msk);

  // a frozen slave shows no ready, or the master would see a handshake that never lands
  assign s_axi_awready = clk_en && !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = clk_en && !w_full && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // settings live only under resetn; the power-down pin never touches them
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl         <= `STP_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `STP_RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ctrl ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
        if (wr_ctrl) begin
          ctrl <= next_ctrl;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // link configuration decode
  wire                  dual    = ctrl[`STP_DUAL_BIT];
  wire [3:0]            lmode   = ctrl[`STP_LMODE_LSB +: 4];
  wire                  mode15  = lmode == `STP_LMODE_15;
  wire stpls_pkg::stpls_test_t tsel = stpls_pkg::stpls_test_t'(ctrl[`STP_TP_LSB +: 4]);
  // lane count depends only on the link mode and part width, never on the test mode
  wire [7:0] lane_on  = mode15 ? (dual ? 8'hff : 8'h0f) : (dual ? 8'h0f : 8'h03);
  wire       alt_eff  = ctrl[`STP_ALT_BIT] && (lane_on[7:4] == 4'h0);
  wire [7:0] phys_on  = alt_eff ? {lane_on[3:0], 4'h0} : lane_on;
  wire       is_prbs  = tsel inside {stpls_pkg::STP_PRBS7, stpls_pkg::STP_PRBS9, stpls_pkg::STP_PRBS15,
                                     stpls_pkg::STP_PRBS23, stpls_pkg::STP_PRBS31};
  wire       is_clock = tsel == stpls_pkg::STP_CLOCK;
  wire       is_ramp  = tsel == stpls_pkg::STP_RAMP;
  wire       is_short = tsel == stpls_pkg::STP_SHORT_TP;
  wire       is_norm  = tsel == stpls_pkg::STP_NORMAL;

  assign lane_drv_en      = power_down_pin ? 8'h00 : phys_on;
  assign link_bypass      = is_prbs || is_clock;
  assign transport_active = !link_bypass && !is_ramp;
  assign link_enc_8b10b   = ctrl[`STP_ENC8B_BIT];
  assign sh_use_fec       = ctrl[`STP_FEC_BIT];
  assign sh_use_crc12     = !ctrl[`STP_FEC_BIT];

  // ==========================================================
  // register reads
  wire [31:0] status = {8'h00, 8'h00, phys_on, 5'h00, alt_eff, ramp_run, power_down_pin};
  wire        rd_ok  = (s_axi_araddr == `STP_CTRL_ADDR) || (s_axi_araddr == `STP_STAT_ADDR);
  wire [31:0] rd_val = (s_axi_araddr == `STP_CTRL_ADDR) ? ctrl :
                       (s_axi_araddr == `STP_STAT_ADDR) ? status : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `STP_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // frame position counters
  logic [3:0] nib_idx;
  logic [1:0] sub_idx;
  logic [2:0] word_idx;
  logic [1:0] clk_ph;
  logic [7:0] ramp_oct;
  logic       ramp_hi;
  logic [71:0] hold_a;
  logic [71:0] hold_b;

  wire frame_last = nib_idx == (mode15 ? `STP_LAST_NIB_M15 : `STP_LAST_NIB_M0);
  wire in_tail    = !mode15 && (nib_idx == `STP_LAST_NIB_M0);
  // in normal mode a fresh frame of samples is taken at each frame boundary, and kept fresh while idle
  assign sample_take = clk_en && is_norm && (frame_last || !link_en);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      nib_idx  <= 4'h0;
      sub_idx  <= 2'd0;
      word_idx <= 3'd0;
    end else if (clk_en) begin
      if (!link_en || frame_last) begin
        nib_idx  <= 4'h0;
        sub_idx  <= 2'd0;
        word_idx <= 3'd0;
      end else begin
        nib_idx  <= nib_idx + 4'h1;
        sub_idx  <= (sub_idx == 2'd2) ? 2'd0 : sub_idx + 2'd1;
        word_idx <= (sub_idx == 2'd2) ? word_idx + 3'd1 : word_idx;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_a <= 72'h0;
      hold_b <= 72'h0;
    end else if (sample_take) begin
      hold_a <= sample_a;
      hold_b <= sample_b;
    end
  end

  // ==========================================================
  // clock pattern and ramp sources
  wire ramp_go = is_ramp && link_en && (link_enc_8b10b ? ila_done : serdes_init_done);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_ph   <= 2'd0;
      ramp_run <= 1'b0;
      ramp_oct <= 8'h00;
      ramp_hi  <= 1'b0;
    end else if (clk_en) begin
      clk_ph <= (is_clock && link_en) ? clk_ph + 2'd1 : 2'd0;
      if (!is_ramp || !link_en) begin
        ramp_run <= 1'b0;
      end else if (ramp_go) begin
        ramp_run <= 1'b1;
      end
      if (!ramp_run) begin
        ramp_oct <= 8'h00;
        ramp_hi  <= 1'b0;
      end else begin
        ramp_hi  <= !ramp_hi;
        ramp_oct <= ramp_hi ? ramp_oct + 8'h01 : ramp_oct;
      end
    end
  end

  wire [3:0] clk_nib  = clk_ph[1] ? `STP_CLK_LO_NIB : `STP_CLK_HI_NIB;
  wire [3:0] ramp_nib = ramp_hi ? ramp_oct[3:0] : ramp_oct[7:4];

  // ==========================================================
  // per-lane data
  // four bits of the sequence per clock; the oldest bit leaves on nibble bit 3
  function automatic logic [30:0] prbs_step(input logic [30:0] s, input stpls_pkg::stpls_test_t m);
    logic [30:0] q;
    logic        nb;
    q  = s;
    nb = 1'b0;
    for (int i = 0; i < 4; i++) begin
      unique case (m)
        stpls_pkg::STP_PRBS7:  nb = q[`STP_P7_TA - 1] ^ q[`STP_P7_TB - 1];
        stpls_pkg::STP_PRBS9:  nb = q[`STP_P9_TA - 1] ^ q[`STP_P9_TB - 1];
        stpls_pkg::STP_PRBS15: nb = q[`STP_P15_TA - 1] ^ q[`STP_P15_TB - 1];
        stpls_pkg::STP_PRBS23: nb = q[`STP_P23_TA - 1] ^ q[`STP_P23_TB - 1];
        default:               nb = q[`STP_P31_TA - 1] ^ q[`STP_P31_TB - 1];
      endcase
      q = {q[29:0], nb};
    end
    return q;
  endfunction : prbs_step

  logic [7:0][3:0] log_nib;
  logic [7:0][3:0] phys_nib;
  logic [30:0]     prbs_q [8];

  for (genvar l = 0; l < 8; l++) begin : g_lane
    logic [8:0]  smp0;
    logic [8:0]  smp1;
    if (l < 4) begin : g_a
      assign smp0 = hold_a[9*l +: 9];
      assign smp1 = hold_a[9*(l+4) +: 9];
    end else begin : g_b
      assign smp0 = hold_b[9*(l-4) +: 9];
      assign smp1 = hold_b[9*l +: 9];
    end
    wire [11:0] dword  = (word_idx == 3'd0) ? {smp0, `STP_PAD_BITS} : {smp1, `STP_PAD_BITS};
    // fixed words, identical in every frame
    wire [11:0] stword = {4'hf - 4'(l), 4'(l), 4'(word_idx) + 4'h1};
    wire [11:0] word   = is_short ? stword : dword;
    wire [3:0]  wnib   = (sub_idx == 2'd0) ? word[11:8] : (sub_idx == 2'd1) ? word[7:4] : word[3:0];
    wire [3:0]  fnib   = in_tail ? `STP_TAIL_NIB : wnib;

    // distinct nonzero seed per lane gives each lane its own phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        prbs_q[l] <= 31'(l + 1);
      end else if (clk_en) begin
        prbs_q[l] <= (is_prbs && link_en) ? prbs_step(prbs_q[l], tsel) : 31'(l + 1);
      end
    end

    assign log_nib[l] = is_prbs  ? prbs_q[l][3:0] :
                        is_clock ? clk_nib :
                        is_ramp  ? (ramp_run ? ramp_nib : 4'h0) :
                        (mode15 || is_short) ? fnib : 4'h0;
    if (l < 4) begin : g_lo
      assign phys_nib[l] = alt_eff ? 4'h0 : log_nib[l];
    end else begin : g_hi
      assign phys_nib[l] = alt_eff ? log_nib[l-4] : log_nib[l];
    end
  end

  wire [31:0] next_lane = phys_nib & {{4{phys_on[7]}}, {4{phys_on[6]}}, {4{phys_on[5]}}, {4{phys_on[4]}},
                                      {4{phys_on[3]}}, {4{phys_on[2]}}, {4{phys_on[1]}}, {4{phys_on[0]}}};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_nibble <= 32'h0000_0000;
    end else if (clk_en) begin
      lane_nibble <= link_en ? next_lane : 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  pd_drivers_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    power_down_pin |-> lane_drv_en == 8'h00) else $error("drivers on during power-down");

  group_excl_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    alt_eff |-> lane_drv_en[3:0] == 4'h0) else $error("default group active in alternate");

  alt_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (alt_eff && !power_down_pin) |-> lane_drv_en == {lane_on[3:0], 4'h0}) else $error("alternate routing wrong");

  redund_only_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    alt_eff |-> (mode15 ? !dual : 1'b1)) else $error("redundancy with eight lanes");

  bypass_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (is_prbs || is_clock) |-> link_bypass && !transport_active) else $error("bypass not set");

  ramp_layers_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_ramp |-> !link_bypass && !transport_active) else $error("ramp layer control wrong");

  ramp_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(ramp_run) |-> $past(ramp_go)) else $error("ramp started early");

  sequence ramp_two_s;
    (ramp_run && clk_en && ramp_hi) ##1 (ramp_run && clk_en);
  endsequence
  ramp_step_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ramp_two_s |-> ramp_oct == $past(ramp_oct) + 8'h01) else $error("ramp octet not stepping");

  tp_locked_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($past(link_en) && link_en) |-> $stable(ctrl[`STP_TP_LSB +: 4])) else $error("pattern changed live");

  regs_kept_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (power_down_pin && !do_write) |=> $stable(ctrl)) else $error("settings lost in power-down");

  sh_mode_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sh_use_crc12 != sh_use_fec) else $error("sync header mode not one-hot");

  clk_pat_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (is_clock && link_en && clk_en && !alt_eff && clk_ph == 2'd1) |=> lane_nibble[3:0] == `STP_CLK_HI_NIB)
    else $error("clock pattern wrong");

endmodule : stpls_top
`default_nettype wire

// File: verilog/stpls_params.svh
`ifndef STPLS_PARAMS_SVH
`define STPLS_PARAMS_SVH

// register byte addresses
`define STP_CTRL_ADDR     8'h00
`define STP_STAT_ADDR     8'h04

// control word fields
`define STP_LINK_EN_BIT   0
`define STP_DUAL_BIT      1
`define STP_ALT_BIT       2
`define STP_FEC_BIT       3
`define STP_ENC8B_BIT     4
`define STP_LMODE_LSB     8
`define STP_TP_LSB        16
`define STP_CTRL_RESET    32'h0000_0f00
`define STP_CTRL_WMASK    32'h000f_0f1f
`define STP_TP_MASK       32'h000f_0000

// status word fields
`define STP_ST_PD_BIT     0
`define STP_ST_RAMP_BIT   1
`define STP_ST_ALT_BIT    2
`define STP_ST_LANE_LSB   8

// link modes handled here
`define STP_LMODE_0       4'h0
`define STP_LMODE_15      4'hf

// frame shape, counted in nibbles (last index)
`define STP_LAST_NIB_M15  4'd5
`define STP_LAST_NIB_M0   4'd15
`define STP_TAIL_NIB      4'h0
`define STP_PAD_BITS      3'b000
`define STP_CLK_HI_NIB    4'hf
`define STP_CLK_LO_NIB    4'h0

// prbs taps, as delays of earlier bits
`define STP_P7_TA         6
`define STP_P7_TB         7
`define STP_P9_TA         5
`define STP_P9_TB         9
`define STP_P15_TA        14
`define STP_P15_TB        15
`define STP_P23_TA        18
`define STP_P23_TB        23
`define STP_P31_TA        28
`define STP_P31_TB        31

// axi responses
`define STP_RESP_OKAY     2'b00
`define STP_RESP_SLVERR   2'b10

`endif

// File: verilog/stpls_pkg.sv
package stpls_pkg;

  typedef enum logic [3:0] {
    STP_NORMAL,
    STP_PRBS7,
    STP_PRBS9,
    STP_PRBS15,
    STP_PRBS23,
    STP_PRBS31,
    STP_CLOCK,
    STP_RAMP,
    STP_SHORT_TP
  } stpls_test_t;

endpackage : stpls_pkg

// File: sim/stpls_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module stpls_rx_model (
  input  wire logic        sys_clk,
  input  wire logic [31:0] lane_nibble,
  input  wire logic [7:0]  lane_drv_en,
  output logic             serdes_init_done,
  output logic             ila_done
);
  // ========
  // lane capture, newest nibble at the low end
  logic [127:0] hist [8];
  logic [3:0]   up_cnt = 4'h0;

  // a dark lane reads back inverted, never as a frozen copy of its last nibble
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < 8; l++) begin
      hist[l] <= {hist[l][123:0], lane_drv_en[l] ? lane_nibble[4*l +: 4] : ~hist[l][3:0]};
    end
  end

  // ========
  // link bring-up
  // all drivers dark drops the link; the count restarts so stale data is not trusted
  always_ff @(posedge sys_clk) begin
    if (lane_drv_en == 8'h00) begin
      up_cnt <= 4'h0;
    end else if (up_cnt != 4'hf) begin
      up_cnt <= up_cnt + 4'h1;
    end
  end

  assign serdes_init_done = (up_cnt >= 4'h8);
  assign ila_done         = (up_cnt == 4'hf);
endmodule : stpls_rx_model

`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stpls_params.svh"

module tb_top;
  // ========
  // signals
  logic        sys_clk = 1'b0;
  logic        resetn, clk_en, power_down_pin, sample_take, link_bypass, transport_active;
  logic        link_enc_8b10b, sh_use_crc12, sh_use_fec, serdes_init_done, ila_done;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, lane_drv_en;
  logic [31:0] s_axi_wdata, s_axi_rdata, lane_nibble, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [71:0] sample_a, sample_b;
  int          num_errors = 0;
  int          checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  stpls_top u_stpls_top (.sys_clk, .resetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_down_pin, .serdes_init_done, .ila_done, .sample_a, .sample_b, .sample_take, .lane_nibble,
    .lane_drv_en, .link_bypass, .transport_active, .link_enc_8b10b, .sh_use_crc12, .sh_use_fec);

  stpls_rx_model u_stpls_rx_model (.sys_clk, .lane_nibble, .lane_drv_en, .serdes_init_done, .ila_done);

  // ========
  // checking and bus helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic give_up(input int n);
    if (n >= 64) begin
      check("bus answer", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : give_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok) && n < 64) begin
      @(posedge sys_clk);
      n++;
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!s_axi_bvalid && n < 64);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    give_up(n);
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    int   n;
    logic ar_ok;
    n = 0;
    ar_ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (!ar_ok && s_axi_arready) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(ar_ok && s_axi_rvalid) && n < 64);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    give_up(n);
  endtask : rd_reg

  function automatic logic [31:0] mk(input logic [3:0] tp, input logic [3:0] md, input logic [4:0] fl);
    return {12'h000, tp, 4'h0, md, 3'h0, fl};
  endfunction : mk

  function automatic logic [3:0] nib(input int l, input int k);
    return u_stpls_rx_model.hist[l][127-4*k -: 4];
  endfunction : nib

  // the select field is written only with the link down
  task automatic setup(input logic [3:0] tp, input logic [3:0] md, input logic [4:0] fl);
    wr(`STP_CTRL_ADDR, 32'h0);
    wr(`STP_CTRL_ADDR, mk(tp, md, fl));
    wr(`STP_CTRL_ADDR, mk(tp, md, fl | 5'h01));
    repeat (40) @(posedge sys_clk);
  endtask : setup

  // frame phase is unknown, so any rotation of the pattern is accepted
  task automatic expect_cycle(input string what, input int l, input logic [63:0] pat, input int len);
    logic hit;
    logic ok;
    hit = 1'b0;
    for (int o = 0; o < len; o++) begin
      ok = 1'b1;
      for (int i = 0; i < len; i++) ok &= (nib(l, o + i) === pat[4*(len-1-i) +: 4]);
      hit |= ok;
    end
    check(what, hit, 1'b1);
  endtask : expect_cycle

  // ========
  // scenarios
  task automatic t_regs();
    rd_reg(`STP_CTRL_ADDR);
    check("ctrl reset", rd, `STP_CTRL_RESET);
    check("lanes at reset", lane_drv_en, 8'h0f);
    check("crc12 default", {sh_use_crc12, sh_use_fec}, 2'b10);
    check("idle sample take", sample_take, 1'b1);
    rd_reg(8'h08);
    check("unmapped read", rsp, `STP_RESP_SLVERR);
    wr(`STP_STAT_ADDR, 32'hffff_ffff);
    check("status write", rsp, `STP_RESP_SLVERR);
    wr(`STP_CTRL_ADDR, 32'h0000_0f18);
    check("fec select", {sh_use_crc12, sh_use_fec}, 2'b01);
    check("8b10b select", link_enc_8b10b, 1'b1);
  endtask : t_regs

  task automatic t_lanes();
    logic [31:0] cfg [4] = '{32'h0000_0f04, 32'h0000_0f06, 32'h0000_0004, 32'h0000_0002};
    logic [7:0]  en  [4] = '{8'hf0, 8'hff, 8'h30, 8'h0f};
    for (int i = 0; i < 4; i++) begin
      wr(`STP_CTRL_ADDR, cfg[i]);
      check("lane enables", lane_drv_en, en[i]);
    end
  endtask : t_lanes

  task automatic t_pd();
    wr(`STP_CTRL_ADDR, 32'h0000_0f04);
    power_down_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("drivers in power-down", lane_drv_en, 8'h00);
    rd_reg(`STP_STAT_ADDR);
    check("power-down status", rd[`STP_ST_PD_BIT], 1'b1);
    rd_reg(`STP_CTRL_ADDR);
    check("ctrl kept", rd, 32'h0000_0f04);
    power_down_pin <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check("drivers back", lane_drv_en, 8'hf0);
  endtask : t_pd

  task automatic t_data();
    setup(stpls_pkg::STP_NORMAL, `STP_LMODE_15, 5'h02);
    expect_cycle("lane0 words", 0, {40'h0, sample_a[8:0], 3'b000, sample_a[44:36], 3'b000}, 6);
    expect_cycle("lane5 words", 5, {40'h0, sample_b[17:9], 3'b000, sample_b[53:45], 3'b000}, 6);
  endtask : t_data

  task automatic t_prbs();
    int ta [5] = '{6, 5, 14, 18, 28};
    int tb [5] = '{7, 9, 15, 23, 31};
    int bad;
    logic [127:0] h;
    for (int m = 0; m < 5; m++) begin
      setup(stpls_pkg::STP_PRBS7 + 4'(m), `STP_LMODE_15, 5'h02);
      bad = 0;
      // stream bit n sits at history bit 127-n, oldest first
      h = u_stpls_rx_model.hist[0];
      for (int n = 31; n < 128; n++) begin
        bad += int'(h[127 - n] !== (h[127 - n + ta[m]] ^ h[127 - n + tb[m]]));
      end
      check("prbs recurrence", bad, 0);
      check("prbs phases", u_stpls_rx_model.hist[0] !== u_stpls_rx_model.hist[1], 1'b1);
      check("prbs bypass", {link_bypass, transport_active}, 2'b10);
      check("prbs no samples", sample_take, 1'b0);
    end
  endtask : t_prbs

  task automatic t_clock();
    setup(stpls_pkg::STP_CLOCK, `STP_LMODE_15, 5'h02);
    expect_cycle("clock lane0", 0, 64'hff00, 4);
    expect_cycle("clock lane7", 7, 64'hff00, 4);
    check("clock bypass", link_bypass, 1'b1);
    clk_en <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check("frozen lane", {nib(0, 29), nib(0, 30)}, {2{nib(0, 31)}});
    clk_en <= 1'b1;
  endtask : t_clock

  task automatic t_ramp();
    logic hit;
    logic ok;
    setup(stpls_pkg::STP_RAMP, `STP_LMODE_15, 5'h02);
    hit = 1'b0;
    for (int o = 0; o < 2; o++) begin
      ok = 1'b1;
      for (int k = 0; k < 14; k++) begin
        ok &= ({nib(0, o+2*k+2), nib(0, o+2*k+3)} === 8'({nib(0, o+2*k), nib(0, o+2*k+1)} + 8'h01));
      end
      hit |= ok;
    end
    check("ramp count", hit, 1'b1);
    check("ramp same lanes", u_stpls_rx_model.hist[0] === u_stpls_rx_model.hist[6], 1'b1);
    check("ramp layers", {link_bypass, transport_active}, 2'b00);
    rd_reg(`STP_STAT_ADDR);
    check("ramp running", rd[`STP_ST_RAMP_BIT], 1'b1);
    wr(`STP_CTRL_ADDR, mk(stpls_pkg::STP_CLOCK, `STP_LMODE_15, 5'h03));
    rd_reg(`STP_CTRL_ADDR);
    check("select locked", rd[19:16], stpls_pkg::STP_RAMP);
  endtask : t_ramp

  task automatic t_short();
    logic [63:0] p;
    setup(stpls_pkg::STP_SHORT_TP, `STP_LMODE_0, 5'h02);
    for (int l = 0; l < 4; l += 3) begin
      p = 64'h0;
      for (int w = 1; w <= 5; w++) p = {p[51:0], 4'hf - 4'(l), 4'(l), 4'(w)};
      p = {p[59:0], `STP_TAIL_NIB};
      expect_cycle("short frame", l, p, 16);
    end
    check("short lanes on", lane_drv_en, 8'h0f);
  endtask : t_short

  // ========
  // main sequence
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    power_down_pin = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    sample_a = 72'h9b_5c3e_71a2_48d6_f01e;
    sample_b = 72'h3c_e1a7_5b90_2fd4_86c1;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    $display("registers done");
    t_lanes();
    $display("lane groups done");
    t_pd();
    $display("power-down done");
    t_data();
    $display("data packing done");
    t_prbs();
    $display("prbs done");
    t_clock();
    $display("clock pattern done");
    t_ramp();
    $display("ramp done");
    t_short();
    $display("short transport done");
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
